// ### hw/sbank_defines.vh
`ifndef SBANK_DEFINES_VH
`define SBANK_DEFINES_VH

// ****************************************************************
// Register map
// ****************************************************************
`define SBANK_ADDR_W 7
`define SBANK_DATA_W 16
`define SBANK_ADDR_WAKE_LVL 7'h45
`define SBANK_ADDR_HS_FAULT 7'h46
`define SBANK_ADDR_BRIDGE_GENERAL_STATUS 7'h50
`define SBANK_RST_VAL 16'h0000

// ****************************************************************
// Field positions, active mode code, channel count and sync width
// ****************************************************************
`define SBANK_OT_HI 13
`define SBANK_OT_LO 10
`define SBANK_OL_HI 8
`define SBANK_OL_LO 5
`define SBANK_OC_HI 3
`define SBANK_OC_LO 0
`define SBANK_VOUT_HI 9
`define SBANK_VOUT_LO 6
`define SBANK_PWM3_BIT 2
`define SBANK_PWM1_BIT 0
`define SBANK_WAKE_HI 3
`define SBANK_WAKE_LO 0
`define SBANK_MODE_ACTIVE 2'b11
`define SBANK_NCH 4
`define SBANK_SYNC_W 22

`endif

// ### hw/sbank_sync.v
`timescale 1ns/100ps
// ****************************************************************
// Two-stage synchroniser, one chain per bit
// ****************************************************************
module sbank_sync #(
   parameter WIDTH = 1
) (
   core_clk,
   sys_rst,
   async_in,
   sync_out
);
   input wire core_clk;
   input wire sys_rst;
   input wire [WIDTH-1:0] async_in;
   output wire [WIDTH-1:0] sync_out;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg meta_q;
         reg stable_q;
         // First stage is read by the second stage only
         always @(posedge core_clk) begin
            if (sys_rst) begin
               meta_q <= 1'b0;
               stable_q <= 1'b0;
            end else begin
               meta_q <= async_in[i];
               stable_q <= meta_q;
            end
         end
         assign sync_out[i] = stable_q;
      end
   endgenerate
endmodule

// ### hw/sbank_top.v
`timescale 1ns/100ps
`include "sbank_defines.vh"
module sbank_top (
   core_clk,
   sys_rst,
   soft_rst,
   restart_evt,
   reg_addr,
   reg_rd_stb,
   reg_wr_stb,
   reg_wdata,
   reg_rdata,
   reg_rvalid,
   wake_pin,
   wake_update_mode,
   cyclic_active,
   wake_sample_stb,
   overtemp_det,
   open_load_det,
   overcurrent_det,
   bridge_out_cmp,
   pwm_input1_pin,
   pwm_input3_pin,
   bridge_mode_field,
   charge_pump_enable,
   wake_input_level_status,
   high_side_fault_status,
   bridge_general_status
);
   input wire core_clk;
   input wire sys_rst;
   input wire soft_rst;
   input wire restart_evt;
   input wire [`SBANK_ADDR_W-1:0] reg_addr;
   input wire reg_rd_stb;
   input wire reg_wr_stb;
   input wire [`SBANK_DATA_W-1:0] reg_wdata;
   output reg [`SBANK_DATA_W-1:0] reg_rdata;
   output reg reg_rvalid;
   input wire [`SBANK_NCH-1:0] wake_pin;
   input wire wake_update_mode;
   input wire cyclic_active;
   input wire wake_sample_stb;
   input wire [`SBANK_NCH-1:0] overtemp_det;
   input wire [`SBANK_NCH-1:0] open_load_det;
   input wire [`SBANK_NCH-1:0] overcurrent_det;
   input wire [`SBANK_NCH-1:0] bridge_out_cmp;
   input wire pwm_input1_pin;
   input wire pwm_input3_pin;
   input wire [2*`SBANK_NCH-1:0] bridge_mode_field;
   input wire charge_pump_enable;
   output wire [`SBANK_DATA_W-1:0] wake_input_level_status;
   output wire [`SBANK_DATA_W-1:0] high_side_fault_status;
   output wire [`SBANK_DATA_W-1:0] bridge_general_status;

   // ****************************************************************
   // Pin synchronisation
   // ****************************************************************
   wire [`SBANK_SYNC_W-1:0] pins_s;
   wire [`SBANK_NCH-1:0] wake_s;
   wire [`SBANK_NCH-1:0] ot_s;
   wire [`SBANK_NCH-1:0] ol_s;
   wire [`SBANK_NCH-1:0] oc_s;
   wire [`SBANK_NCH-1:0] vout_s;
   wire pwm1_s;
   wire pwm3_s;

   sbank_sync #(
      .WIDTH(`SBANK_SYNC_W)
   ) u_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in({pwm_input3_pin, pwm_input1_pin, bridge_out_cmp,
                 overcurrent_det, open_load_det, overtemp_det,
                 wake_pin}),
      .sync_out(pins_s)
   );

   // Same field order as the chain input, so no positions are spelled out
   assign {pwm3_s, pwm1_s, vout_s, oc_s, ol_s, ot_s, wake_s} = pins_s;

   // ****************************************************************
   // Access decode
   // ****************************************************************
   wire rd_fault;
   wire rd_gen;
   wire rd_wake;
   wire hard_clr;

   assign rd_fault = reg_rd_stb && (reg_addr == `SBANK_ADDR_HS_FAULT);
   assign rd_gen = reg_rd_stb && (reg_addr == `SBANK_ADDR_BRIDGE_GENERAL_STATUS);
   assign rd_wake = reg_rd_stb && (reg_addr == `SBANK_ADDR_WAKE_LVL);
   // Soft reset acts like power-on for these registers
   assign hard_clr = sys_rst || soft_rst;

   // ****************************************************************
   // Wake input levels
   // ****************************************************************
   reg [`SBANK_NCH-1:0] wake_lvl_q;
   reg [`SBANK_NCH-1:0] wake_lvl_d;
   always @* begin
      wake_lvl_d = wake_lvl_q;
      if (wake_update_mode) begin
         if (!cyclic_active) begin
            wake_lvl_d = wake_s;
         end else if (wake_sample_stb) begin
            // Holds between samples so reads see the sampled level
            wake_lvl_d = wake_s;
         end
      end
   end

   always @(posedge core_clk) begin
      if (hard_clr) begin
         wake_lvl_q <= {`SBANK_NCH{1'b0}};
      end else begin
         wake_lvl_q <= wake_lvl_d;
      end
   end

   // ****************************************************************
   // High-side fault flags, cleared on read
   // ****************************************************************
   reg [`SBANK_NCH-1:0] ot_q;
   reg [`SBANK_NCH-1:0] ol_q;
   reg [`SBANK_NCH-1:0] oc_q;
   reg [`SBANK_NCH-1:0] ot_d;
   reg [`SBANK_NCH-1:0] ol_d;
   reg [`SBANK_NCH-1:0] oc_d;

   always @* begin
      ot_d = ot_q;
      ol_d = ol_q;
      oc_d = oc_q;
      if (rd_fault) begin
         ot_d = {`SBANK_NCH{1'b0}};
         ol_d = {`SBANK_NCH{1'b0}};
         oc_d = {`SBANK_NCH{1'b0}};
      end
      // Set after clear so an event in the read cycle survives
      ot_d = ot_d | ot_s;
      ol_d = ol_d | ol_s;
      oc_d = oc_d | oc_s;
   end

   always @(posedge core_clk) begin
      if (hard_clr) begin
         ot_q <= {`SBANK_NCH{1'b0}};
         ol_q <= {`SBANK_NCH{1'b0}};
         oc_q <= {`SBANK_NCH{1'b0}};
      end else begin
         // A restart leaves the flags untouched
         ot_q <= ot_d;
         ol_q <= ol_d;
         oc_q <= oc_d;
      end
   end

   // ****************************************************************
   // Bridge general status
   // ****************************************************************
   reg [`SBANK_NCH-1:0] vout_q;
   reg pwm1_q;
   reg pwm3_q;
   wire [`SBANK_NCH-1:0] vout_qual;

   genvar h;
   generate
      for (h = 0; h < `SBANK_NCH; h = h + 1) begin : g_hb
         // Level only means something while the bridge is driven
         assign vout_qual[h] = vout_s[h] && charge_pump_enable &&
            (bridge_mode_field[2*h+1:2*h] == `SBANK_MODE_ACTIVE);
      end
   endgenerate

   always @(posedge core_clk) begin
      if (hard_clr) begin
         vout_q <= {`SBANK_NCH{1'b0}};
         pwm1_q <= 1'b0;
         pwm3_q <= 1'b0;
      end else if (restart_evt) begin
         // Restart keeps only the live bits 7:6 and 0
         vout_q <= {2'b00, vout_qual[1:0]};
         pwm1_q <= pwm1_s;
         pwm3_q <= 1'b0;
      end else begin
         vout_q <= vout_qual;
         pwm1_q <= pwm1_s;
         pwm3_q <= pwm3_s;
      end
   end

   // ****************************************************************
   // Register images and read port
   // ****************************************************************
   reg [`SBANK_DATA_W-1:0] fault_img;
   reg [`SBANK_DATA_W-1:0] gen_img;
   reg [`SBANK_DATA_W-1:0] wake_img;

   always @* begin
      // Reserved positions stay zero; writes never reach them
      fault_img = `SBANK_RST_VAL;
      fault_img[`SBANK_OT_HI:`SBANK_OT_LO] = ot_q;
      fault_img[`SBANK_OL_HI:`SBANK_OL_LO] = ol_q;
      fault_img[`SBANK_OC_HI:`SBANK_OC_LO] = oc_q;
      gen_img = `SBANK_RST_VAL;
      gen_img[`SBANK_VOUT_HI:`SBANK_VOUT_LO] = vout_q;
      gen_img[`SBANK_PWM3_BIT] = pwm3_q;
      gen_img[`SBANK_PWM1_BIT] = pwm1_q;
      wake_img = `SBANK_RST_VAL;
      wake_img[`SBANK_WAKE_HI:`SBANK_WAKE_LO] = wake_lvl_q;
   end

   assign high_side_fault_status = fault_img;
   assign bridge_general_status = gen_img;
   assign wake_input_level_status = wake_img;

   // Writes are accepted and dropped: all three registers are status
   always @(posedge core_clk) begin
      if (sys_rst) begin
         reg_rdata <= `SBANK_RST_VAL;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd_stb;
         if (rd_fault) begin
            reg_rdata <= fault_img;
         end else if (rd_gen) begin
            reg_rdata <= gen_img;
         end else if (rd_wake) begin
            reg_rdata <= wake_img;
         end else if (reg_rd_stb) begin
            reg_rdata <= `SBANK_RST_VAL;
         end
      end
   end
endmodule

// ### test/sbank_monitor.sv
`timescale 1ns/100ps
module sbank_monitor (
   input wire core_clk,
   input wire sys_rst,
   input wire soft_rst,
   input wire restart_evt,
   input wire [6:0] reg_addr,
   input wire reg_rd_stb,
   input wire reg_rvalid,
   input wire [15:0] reg_rdata,
   input wire [3:0] overtemp_det,
   input wire [3:0] open_load_det,
   input wire [3:0] overcurrent_det,
   input wire pwm_input1_pin,
   input wire charge_pump_enable,
   input wire [15:0] high_side_fault_status,
   input wire [15:0] bridge_general_status
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // ****
   // Read timing, clear-on-read, reserved bits, pump gating, pwm mirror, reset and restart
   // ****
   sequence s_quiet;
      (overtemp_det == 4'h0 && open_load_det == 4'h0
       && overcurrent_det == 4'h0 && !soft_rst)[*4];
   endsequence
   sequence s_fault_rd;
      reg_rd_stb && reg_addr == 7'h46;
   endsequence
   AST_RVALID: assert property (reg_rvalid == $past(reg_rd_stb))
      else $error("read answer not one cycle after strobe");
   AST_RD_DATA: assert property (s_fault_rd |=>
      reg_rdata == $past(high_side_fault_status))
      else $error("read data differs from flags at read");
   AST_RD_CLR: assert property (s_quiet ##0 s_fault_rd |=>
      high_side_fault_status == 16'h0000)
      else $error("flags not cleared by read");
   AST_HS_RSV: assert property (high_side_fault_status[15:14] == 2'h0
      && !high_side_fault_status[9] && !high_side_fault_status[4])
      else $error("reserved fault bit set");
   AST_GEN_RSV: assert property (bridge_general_status[15:10] == 6'h00
      && bridge_general_status[5:3] == 3'h0 && !bridge_general_status[1])
      else $error("reserved general bit set");
   AST_PUMP_OFF: assert property ((!charge_pump_enable)[*4] |->
      bridge_general_status[9:6] == 4'h0)
      else $error("bridge level shown with pump off");
   AST_PWM1: assert property ((pwm_input1_pin && !soft_rst)[*4] |->
      bridge_general_status[0])
      else $error("first pwm level not mirrored");
   AST_RST_CLR: assert property ($fell(sys_rst) |->
      high_side_fault_status == 16'h0000 && !reg_rvalid
      && bridge_general_status == 16'h0000)
      else $error("registers not zero after reset");
   AST_RESTART: assert property (restart_evt && !reg_rd_stb && !soft_rst |=>
      ($past(high_side_fault_status[13:0]) & ~high_side_fault_status[13:0])
      == 14'h0000)
      else $error("restart lost a fault flag");
endmodule
bind sbank_top sbank_monitor sbank_monitor_i (.*);

// ### test/sbank_host.sv
`timescale 1ns/100ps
module sbank_host (
   input wire core_clk,
   input wire rd_req,
   input wire [6:0] rd_addr,
   output logic reg_rd_stb,
   output logic [6:0] reg_addr,
   input wire reg_rvalid,
   input wire [15:0] reg_rdata,
   output logic rd_done,
   output logic [15:0] rd_data
);
   initial begin
      reg_rd_stb = 1'b0;
      reg_addr = 7'h00;
      rd_done = 1'b0;
      rd_data = 16'h0000;
   end
   // Idle address is scrambled so a stale decode cannot pass
   always @(posedge core_clk) begin
      reg_rd_stb <= rd_req;
      reg_addr <= rd_req ? rd_addr : ~reg_addr;
      rd_done <= reg_rvalid;
      if (reg_rvalid) begin
         rd_data <= reg_rdata;
      end
   end
endmodule

// ### test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   logic core_clk, sys_rst, soft_rst, restart_evt, reg_rd_stb, reg_wr_stb;
   logic reg_rvalid, wake_update_mode, cyclic_active, wake_sample_stb;
   logic pwm_input1_pin, pwm_input3_pin, charge_pump_enable, rd_req, rd_done;
   logic [6:0] reg_addr, rd_addr;
   logic [15:0] reg_wdata, reg_rdata, rd_data, wake_input_level_status;
   logic [15:0] high_side_fault_status, bridge_general_status;
   logic [3:0] wake_pin, overtemp_det, open_load_det, overcurrent_det;
   logic [3:0] bridge_out_cmp, w, f0, f1, f2;
   logic [7:0] bridge_mode_field;
   int n_errors, check_count, i, k;
   sbank_top sbank_top_i (.*);
   sbank_host sbank_host_i (.*);
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      #100000;
      n_errors++;
      stop_test;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic rd(input logic [6:0] a, input logic [15:0] exp);
      int t;
      rd_addr = a;
      rd_req = 1'b1;
      tick(1);
      rd_req = 1'b0;
      t = 0;
      while (rd_done !== 1'b1 && t < 8) begin
         tick(1);
         t++;
      end
      chk({15'h0, rd_done}, 16'h0001);
      chk(rd_data, exp);
   endtask
   task automatic fault(input logic [3:0] a, input logic [3:0] b,
                        input logic [3:0] c);
      {overtemp_det, open_load_det, overcurrent_det} = {a, b, c};
      tick(1);
      {overtemp_det, open_load_det, overcurrent_det} = 12'h000;
      tick(4);
   endtask
   function automatic logic [15:0] gen_exp();
      logic [3:0] v;
      for (int j = 0; j < 4; j++) begin
         v[j] = charge_pump_enable && bridge_mode_field[2*j+:2] == 2'b11
                && bridge_out_cmp[j];
      end
      return {6'h00, v, 3'h0, pwm_input3_pin, 1'b0, pwm_input1_pin};
   endfunction
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      {soft_rst, restart_evt, reg_wr_stb, rd_req, wake_update_mode} = 5'h00;
      {cyclic_active, wake_sample_stb, pwm_input1_pin, pwm_input3_pin} = 4'h0;
      {charge_pump_enable, bridge_mode_field, bridge_out_cmp} = 13'h0000;
      {overtemp_det, open_load_det, overcurrent_det, wake_pin} = 16'h0000;
      {reg_wdata, rd_addr, n_errors, check_count} = 0;
      sys_rst = 1'b1;
      k = $urandom(25);
      repeat (8) @(posedge core_clk);
      #1 sys_rst = 1'b0;
      rd(7'h46, 16'h0000);
      rd(7'h50, 16'h0000);
      rd(7'h45, 16'h0000);
      rd(7'h10, 16'h0000);
      $display("reset values done");
      for (i = 0; i < 12; i++) begin
         {f0, f1, f2} = (i == 0) ? 12'hfff : 12'($urandom);
         reg_wr_stb = 1'b1;
         reg_wdata = 16'hffff;
         fault(f0, f1, f2);
         reg_wr_stb = 1'b0;
         rd(7'h46, {2'h0, f0, 1'b0, f1, 1'b0, f2});
         rd(7'h46, 16'h0000);
      end
      overcurrent_det = 4'h2;
      tick(4);
      rd(7'h46, 16'h0002);
      rd(7'h46, 16'h0002);
      overcurrent_det = 4'h0;
      tick(3);
      rd(7'h46, 16'h0002);
      rd(7'h46, 16'h0000);
      fault(4'h5, 4'ha, 4'h3);
      restart_evt = 1'b1;
      tick(1);
      restart_evt = 1'b0;
      rd(7'h46, 16'h1543);
      fault(4'h9, 4'h6, 4'hc);
      soft_rst = 1'b1;
      tick(1);
      soft_rst = 1'b0;
      rd(7'h46, 16'h0000);
      $display("fault flags done");
      for (i = 0; i < 16; i++) begin
         {bridge_mode_field, bridge_out_cmp} = 12'($urandom);
         {charge_pump_enable, pwm_input1_pin, pwm_input3_pin} = 3'($urandom);
         if (i < 2) begin
            {bridge_mode_field, bridge_out_cmp} = 12'hfff;
            charge_pump_enable = (i == 0);
         end
         tick(4);
         rd(7'h50, gen_exp());
      end
      $display("general status done");
      wake_update_mode = 1'b1;
      for (i = 0; i < 4; i++) begin
         wake_pin = 4'($urandom);
         tick(4);
         chk(wake_input_level_status, {12'h000, wake_pin});
         rd(7'h45, {12'h000, wake_pin});
      end
      cyclic_active = 1'b1;
      w = wake_pin;
      wake_pin = ~w;
      tick(4);
      chk(wake_input_level_status, {12'h000, w});
      rd(7'h45, {12'h000, w});
      wake_sample_stb = 1'b1;
      tick(1);
      wake_sample_stb = 1'b0;
      tick(2);
      rd(7'h45, {12'h000, ~w});
      $display("wake level done");
      stop_test;
   end
endmodule
